/* verilog/cct_pkg.sv */
package cct_pkg;

    // Default word geometry
    localparam int BIN_W     = 8;
    localparam int DIGITS    = 3;
    localparam int OVR_W     = 2;
    localparam int WORD_W    = 16;
    localparam int VAL_W     = 16;
    localparam int BUF_DEPTH = 2;

    // Arithmetic constants
    localparam logic [VAL_W-1:0]  DEC_RADIX = 16'h000A;
    localparam logic [3:0]        DIGIT_MAX = 4'h9;
    localparam logic [3:0]        DD_LIMIT  = 4'h4;
    localparam logic [3:0]        DD_ADJUST = 4'h3;
    localparam logic [WORD_W-1:0] WORD_RST  = 16'h0000;

    typedef enum logic [3:0] {
        CODE_STRAIGHT,
        CODE_COMP_BIN,
        CODE_OFFSET,
        CODE_COMP_OFFSET,
        CODE_TWOS,
        CODE_SIGN_MAG,
        CODE_BCD,
        CODE_COMP_BCD,
        CODE_BCD_OVR,
        CODE_SIGN_BCD
    } cct_code_t;

    typedef struct packed {
        logic invalid;
        logic clamped;
        logic negZero;
    } cct_flags_t;

    typedef struct packed {
        logic [WORD_W-1:0] word;
        cct_flags_t        flags;
    } cct_sample_t;

    localparam cct_sample_t SAMPLE_RST = '{word: WORD_RST, flags: 3'h0};

endpackage

/* verilog/cct_bcd.sv */
`timescale 1ns/1ns
module cct_bcd #(
    parameter int MAG_W = 16,
    parameter int NDIG  = 4
) (
    input  wire logic [MAG_W-1:0]  bin,
    output logic      [4*NDIG-1:0] bcd
);

    // Shift-and-add-three conversion
    always_comb begin
        bcd = '0;
        for (int i = MAG_W - 1; i >= 0; i--) begin
            for (int d = 0; d < NDIG; d++) begin
                if (bcd[4*d +: 4] > cct_pkg::DD_LIMIT) begin
                    bcd[4*d +: 4] = bcd[4*d +: 4] + cct_pkg::DD_ADJUST;
                end
            end
            bcd = {bcd[4*NDIG-2:0], bin[i]};
        end
    end

endmodule

/* verilog/cct_fifo.sv */
`timescale 1ns/1ns
module cct_fifo #(
    parameter int W     = 19,
    parameter int DEPTH = 2
) (
    input  wire logic         mclk,
    input  wire logic         reset,
    input  wire logic         clr,
    input  wire logic         wrValid,
    output logic              wrReady,
    input  wire logic [W-1:0] wrData,
    output logic              rdValid,
    input  wire logic         rdReady,
    output logic      [W-1:0] rdData
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0]   count_q;

    wire push = wrValid && wrReady;
    wire pop  = rdValid && rdReady;

    // Full and empty from the occupancy count
    assign wrReady = count_q != (AW+1)'(DEPTH);
    assign rdValid = count_q != '0;
    assign rdData  = mem[rdPtr_q];

    // Entries cleared with the pointers, so the buffer shows zero after reset or clear
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            mem <= '{default: '0};
        end else if (clr) begin
            mem <= '{default: '0};
        end else if (push) begin
            mem[wrPtr_q] <= wrData;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else if (clr) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

endmodule

/* verilog/cct_translator.sv */
`timescale 1ns/1ns
module cct_translator #(
    parameter int BIN_W  = cct_pkg::BIN_W,
    parameter int DIGITS = cct_pkg::DIGITS,
    parameter int OVR_W  = cct_pkg::OVR_W
) (
    input  wire logic                      mclk,
    input  wire logic                      reset,
    input  wire logic                      syncClr,
    input  wire cct_pkg::cct_code_t        srcCode,
    input  wire cct_pkg::cct_code_t        dstCode,
    input  wire logic                      inValid,
    output logic                           inReady,
    input  wire logic [cct_pkg::WORD_W-1:0] inWord,
    output logic                           outValid,
    input  wire logic                      outReady,
    output logic      [cct_pkg::WORD_W-1:0] outWord,
    output cct_pkg::cct_flags_t            outFlags
);

    localparam int VW       = cct_pkg::VAL_W;
    localparam int DW       = 4 * DIGITS;
    localparam int DEC_FULL = 10 ** DIGITS;
    localparam int HALF     = 1 << (BIN_W - 1);

    // Representable ranges per code family
    localparam logic signed [VW-1:0] UNI_MAX = VW'((1 << BIN_W) - 1);
    localparam logic signed [VW-1:0] BIP_MAX = VW'(HALF - 1);
    localparam logic signed [VW-1:0] BIP_MIN = VW'(-HALF);
    localparam logic signed [VW-1:0] SM_MIN  = VW'(1 - HALF);
    localparam logic signed [VW-1:0] DEC_MAX = VW'(DEC_FULL - 1);
    localparam logic signed [VW-1:0] OVR_MAX = VW'((2 ** OVR_W) * DEC_FULL - 1);
    localparam logic signed [VW-1:0] OVR_MIN = VW'(1 - (2 ** OVR_W) * DEC_FULL);

    function automatic logic [VW-1:0] negate(input logic [VW-1:0] v);
        return ~v + 1'b1;
    endfunction

    function automatic logic digitBad(input logic [DW-1:0] g);
        logic bad;
        bad = 1'b0;
        for (int d = 0; d < DIGITS; d++) begin
            if (g[4*d +: 4] > cct_pkg::DIGIT_MAX) begin
                bad = 1'b1;
            end
        end
        return bad;
    endfunction

    function automatic logic [VW-1:0] bcdValue(
        input logic [DW-1:0]    g,
        input logic [OVR_W-1:0] ovr
    );
        logic [VW-1:0] acc;
        acc = VW'(ovr);
        for (int d = DIGITS - 1; d >= 0; d--) begin
            acc = VW'(acc * cct_pkg::DEC_RADIX + VW'(g[4*d +: 4]));
        end
        return acc;
    endfunction

    // Source family decode
    wire srcUni = (srcCode == cct_pkg::CODE_STRAIGHT) || (srcCode == cct_pkg::CODE_COMP_BIN);
    wire srcSm  = srcCode == cct_pkg::CODE_SIGN_MAG;
    wire srcBip = (srcCode == cct_pkg::CODE_OFFSET) || (srcCode == cct_pkg::CODE_COMP_OFFSET)
               || (srcCode == cct_pkg::CODE_TWOS);
    wire srcCbd = srcCode == cct_pkg::CODE_COMP_BCD;
    wire srcOvr = (srcCode == cct_pkg::CODE_BCD_OVR) || (srcCode == cct_pkg::CODE_SIGN_BCD);
    wire srcSbd = srcCode == cct_pkg::CODE_SIGN_BCD;
    wire srcDec = !srcUni && !srcSm && !srcBip;

    // Binary source words
    wire [BIN_W-1:0] binIn  = inWord[BIN_W-1:0];
    wire [BIN_W-1:0] binCmp = ~binIn;
    wire [BIN_W-1:0] uniSrc = (srcCode == cct_pkg::CODE_COMP_BIN) ? binCmp : binIn;
    wire [BIN_W-1:0] offSrc = (srcCode == cct_pkg::CODE_COMP_OFFSET) ? binCmp : binIn;
    wire [BIN_W-1:0] twosSrc = (srcCode == cct_pkg::CODE_TWOS) ? binIn
                             : {~offSrc[BIN_W-1], offSrc[BIN_W-2:0]};

    wire [VW-1:0] uniVal  = {{(VW-BIN_W){1'b0}}, uniSrc};
    wire [VW-1:0] twosVal = {{(VW-BIN_W){twosSrc[BIN_W-1]}}, twosSrc};

    // Sign-magnitude source
    wire          smPos     = binIn[BIN_W-1];
    wire [VW-1:0] smMag     = {{(VW-BIN_W+1){1'b0}}, binIn[BIN_W-2:0]};
    wire [VW-1:0] smVal     = smPos ? smMag : negate(smMag);
    wire          smNegZero = srcSm && (binIn == '0);

    // Decimal source
    wire [DW-1:0]    bcdGroups = srcCbd ? ~inWord[DW-1:0] : inWord[DW-1:0];
    wire [OVR_W-1:0] ovrIn     = srcOvr ? inWord[DW +: OVR_W] : '0;
    wire             bcdPos    = inWord[DW+OVR_W];
    wire [VW-1:0]    decMag    = bcdValue(bcdGroups, ovrIn);
    wire [VW-1:0]    decVal    = (srcSbd && !bcdPos) ? negate(decMag) : decMag;
    wire             badDigit  = srcDec && digitBad(bcdGroups);

    wire signed [VW-1:0] srcVal = srcUni ? uniVal
                                : srcSm  ? smVal
                                : srcBip ? twosVal
                                : decVal;

    // Destination family decode
    wire dstUni = (dstCode == cct_pkg::CODE_STRAIGHT) || (dstCode == cct_pkg::CODE_COMP_BIN);
    wire dstSm  = dstCode == cct_pkg::CODE_SIGN_MAG;
    wire dstBip = (dstCode == cct_pkg::CODE_OFFSET) || (dstCode == cct_pkg::CODE_COMP_OFFSET)
               || (dstCode == cct_pkg::CODE_TWOS);
    wire dstBcd = (dstCode == cct_pkg::CODE_BCD) || (dstCode == cct_pkg::CODE_COMP_BCD);
    wire dstSbd = dstCode == cct_pkg::CODE_SIGN_BCD;

    // Range limits of the destination
    wire signed [VW-1:0] hiLim = dstUni ? UNI_MAX
                               : (dstBip || dstSm) ? BIP_MAX
                               : dstBcd ? DEC_MAX
                               : OVR_MAX;
    wire signed [VW-1:0] loLim = dstBip ? BIP_MIN
                               : dstSm  ? SM_MIN
                               : dstSbd ? OVR_MIN
                               : '0;

    wire clampHi = srcVal > hiLim;
    wire clampLo = srcVal < loLim;

    wire signed [VW-1:0] val = clampHi ? hiLim : clampLo ? loLim : srcVal;

    wire          valNeg = val[VW-1];
    wire [VW-1:0] valMag = valNeg ? negate(val) : val;

    // Binary destination words
    wire [BIN_W-1:0] uniOut  = val[BIN_W-1:0];
    wire [BIN_W-1:0] cbinOut = ~uniOut;
    wire [BIN_W-1:0] twosOut = val[BIN_W-1:0];
    wire [BIN_W-1:0] offOut  = {~twosOut[BIN_W-1], twosOut[BIN_W-2:0]};
    wire [BIN_W-1:0] coffOut = ~offOut;
    wire [BIN_W-1:0] smOut   = {~valNeg, valMag[BIN_W-2:0]};

    // Decimal destination words
    wire [DW+3:0] bcdDigits;

    cct_bcd #(
        .MAG_W (VW),
        .NDIG  (DIGITS + 1)
    ) u_bcd (
        .bin (valMag),
        .bcd (bcdDigits)
    );

    wire [DW-1:0]    bcdOut = bcdDigits[DW-1:0];
    wire [OVR_W-1:0] ovrOut = bcdDigits[DW +: OVR_W];

    localparam int PAD_B = cct_pkg::WORD_W - BIN_W;
    localparam int PAD_D = cct_pkg::WORD_W - DW;
    localparam int PAD_O = cct_pkg::WORD_W - DW - OVR_W;
    localparam int PAD_S = cct_pkg::WORD_W - DW - OVR_W - 1;

    wire [cct_pkg::WORD_W-1:0] wordOut =
          (dstCode == cct_pkg::CODE_STRAIGHT)    ? {{PAD_B{1'b0}}, uniOut}
        : (dstCode == cct_pkg::CODE_COMP_BIN)    ? {{PAD_B{1'b0}}, cbinOut}
        : (dstCode == cct_pkg::CODE_OFFSET)      ? {{PAD_B{1'b0}}, offOut}
        : (dstCode == cct_pkg::CODE_COMP_OFFSET) ? {{PAD_B{1'b0}}, coffOut}
        : (dstCode == cct_pkg::CODE_TWOS)        ? {{PAD_B{1'b0}}, twosOut}
        : (dstCode == cct_pkg::CODE_SIGN_MAG)    ? {{PAD_B{1'b0}}, smOut}
        : (dstCode == cct_pkg::CODE_BCD)         ? {{PAD_D{1'b0}}, bcdOut}
        : (dstCode == cct_pkg::CODE_COMP_BCD)    ? {{PAD_D{1'b0}}, ~bcdOut}
        : (dstCode == cct_pkg::CODE_BCD_OVR)     ? {{PAD_O{1'b0}}, ovrOut, bcdOut}
        : (dstCode == cct_pkg::CODE_SIGN_BCD)    ? {{PAD_S{1'b0}}, ~valNeg, ovrOut, bcdOut}
        : cct_pkg::WORD_RST;

    cct_pkg::cct_sample_t sampleD;

    assign sampleD.word          = wordOut;
    assign sampleD.flags.invalid = badDigit;
    assign sampleD.flags.clamped = clampHi || clampLo;
    assign sampleD.flags.negZero = smNegZero;

    // Output register stage
    cct_pkg::cct_sample_t stage_q;
    logic                 stageValid_q;
    logic                 bufWrReady;

    wire load = inValid && inReady;

    assign inReady = !stageValid_q || bufWrReady;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            stage_q      <= cct_pkg::SAMPLE_RST;
            stageValid_q <= 1'b0;
        end else if (syncClr) begin
            stage_q      <= cct_pkg::SAMPLE_RST;
            stageValid_q <= 1'b0;
        end else if (load) begin
            stage_q      <= sampleD;
            stageValid_q <= 1'b1;
        end else if (bufWrReady) begin
            stageValid_q <= 1'b0;
        end
    end

    // Two-entry buffer toward the receiver
    localparam int SW = $bits(cct_pkg::cct_sample_t);

    logic [SW-1:0]        bufRdData;
    cct_pkg::cct_sample_t bufOut;

    cct_fifo #(
        .W     (SW),
        .DEPTH (cct_pkg::BUF_DEPTH)
    ) u_fifo (
        .mclk    (mclk),
        .reset   (reset),
        .clr     (syncClr),
        .wrValid (stageValid_q),
        .wrReady (bufWrReady),
        .wrData  (stage_q),
        .rdValid (outValid),
        .rdReady (outReady),
        .rdData  (bufRdData)
    );

    assign bufOut   = bufRdData;
    assign outWord  = bufOut.word;
    assign outFlags = bufOut.flags;

endmodule

/* testbench/cct_translator_checker.sv */
`timescale 1ns/1ns
module cct_translator_checker (
    input wire logic                       mclk,
    input wire logic                       reset,
    input wire logic                       syncClr,
    input wire cct_pkg::cct_code_t         srcCode,
    input wire cct_pkg::cct_code_t         dstCode,
    input wire logic                       inValid,
    input wire logic                       inReady,
    input wire logic [cct_pkg::WORD_W-1:0] inWord,
    input wire logic                       outValid,
    input wire logic                       outReady,
    input wire logic [cct_pkg::WORD_W-1:0] outWord,
    input wire cct_pkg::cct_flags_t        outFlags
);
    logic take;
    logic take_q;
    assign take = inValid && inReady && !syncClr;
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            take_q <= 1'b0;
        end else begin
            take_q <= take;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // Word taken into an empty path
    sequence s_fresh(cct_pkg::cct_code_t s, cct_pkg::cct_code_t d);
        take && !outValid && !take_q && srcCode == s && dstCode == d;
    endsequence
    property p_xlat(cct_pkg::cct_code_t s, cct_pkg::cct_code_t d, logic [15:0] m);
        s_fresh(s, d) ##1 !syncClr |=> outValid && outWord == ($past(inWord, 2) ^ m);
    endproperty
    AST_RDY: assert property (!inReady |-> outValid)
        else $error("input refused with empty output");
    AST_CLR: assert property (syncClr |=> !outValid && outWord == 16'h0000)
        else $error("clear left output valid");
    AST_HOLD: assert property (outValid && !outReady && !syncClr |=>
        outValid && $stable(outWord) && $stable(outFlags)) else $error("stalled output moved");
    AST_LAT: assert property (take && !outValid && !take_q ##1 !syncClr |=> outValid)
        else $error("output not valid two cycles after take");
    AST_COMP_BIN: assert property (p_xlat(cct_pkg::CODE_STRAIGHT,
        cct_pkg::CODE_COMP_BIN, 16'h00FF)) else $error("complementary binary wrong");
    AST_OFF_TWOS: assert property (p_xlat(cct_pkg::CODE_OFFSET,
        cct_pkg::CODE_TWOS, 16'h0080)) else $error("twos from offset wrong");
    AST_COMP_OFF: assert property (p_xlat(cct_pkg::CODE_OFFSET,
        cct_pkg::CODE_COMP_OFFSET, 16'h00FF)) else $error("complementary offset wrong");
    AST_COMP_BCD: assert property (p_xlat(cct_pkg::CODE_BCD,
        cct_pkg::CODE_COMP_BCD, 16'h0FFF)) else $error("complementary decimal wrong");
    AST_INV: assert property (s_fresh(cct_pkg::CODE_BCD, cct_pkg::CODE_STRAIGHT)
        ##0 (inWord[3:0] > cct_pkg::DIGIT_MAX || inWord[7:4] > cct_pkg::DIGIT_MAX
            || inWord[11:8] > cct_pkg::DIGIT_MAX) ##1 !syncClr |=> outFlags.invalid)
        else $error("bad digit not flagged");
endmodule
bind cct_translator cct_translator_checker cct_translator_checker_inst (.mclk(mclk),
    .reset(reset), .syncClr(syncClr), .srcCode(srcCode), .dstCode(dstCode),
    .inValid(inValid), .inReady(inReady), .inWord(inWord), .outValid(outValid),
    .outReady(outReady), .outWord(outWord), .outFlags(outFlags));

/* testbench/cct_sink_model.sv */
`timescale 1ns/1ns
module cct_sink_model (
    input  wire logic                       mclk,
    input  wire logic                       reset,
    input  wire logic                       stall,
    input  wire logic                       outValid,
    output logic                            outReady,
    input  wire logic [cct_pkg::WORD_W-1:0] outWord,
    input  wire cct_pkg::cct_flags_t        outFlags
);
    cct_pkg::cct_sample_t gotQ[$];
    assign outReady = !stall;
    // Capture each accepted word in order
    always @(posedge mclk) begin
        if (!reset && outValid && outReady) begin
            gotQ.push_back('{word: outWord, flags: outFlags});
        end
    end
endmodule

/* testbench/tb_cct_translator.sv */
`timescale 1ns/1ns
module tb_cct_translator;
    logic                 mclk;
    logic                 reset;
    logic                 syncClr;
    logic                 inValid;
    logic                 stall;
    cct_pkg::cct_code_t   srcCode;
    cct_pkg::cct_code_t   dstCode;
    logic [15:0]          inWord;
    logic                 inReady;
    logic                 outValid;
    logic                 outReady;
    logic [15:0]          outWord;
    cct_pkg::cct_flags_t  outFlags;
    cct_pkg::cct_sample_t got;
    cct_pkg::cct_sample_t got2;
    int                   errors;
    int                   tests_run;
    logic [15:0]          fiveTab [10] = '{16'h0005, 16'h00FA, 16'h0085, 16'h007A, 16'h0005,
                                           16'h0085, 16'h0005, 16'h0FFA, 16'h0005, 16'h4005};
    cct_translator cct_translator_inst (.mclk(mclk), .reset(reset), .syncClr(syncClr),
        .srcCode(srcCode), .dstCode(dstCode), .inValid(inValid), .inReady(inReady),
        .inWord(inWord), .outValid(outValid), .outReady(outReady), .outWord(outWord),
        .outFlags(outFlags));
    cct_sink_model cct_sink_model_inst (.mclk(mclk), .reset(reset), .stall(stall),
        .outValid(outValid), .outReady(outReady), .outWord(outWord), .outFlags(outFlags));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task conclude;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task check(input logic [18:0] seen, input logic [18:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task send(input cct_pkg::cct_code_t s, input cct_pkg::cct_code_t d, input logic [15:0] w);
        @(negedge mclk);
        srcCode = s;
        dstCode = d;
        inWord = w;
        inValid = 1'b1;
        for (int i = 0; i < 40 && inReady !== 1'b1; i++) @(negedge mclk);
        if (inReady !== 1'b1) errors++;
        @(posedge mclk);
    endtask
    task xlat(input cct_pkg::cct_code_t s, input cct_pkg::cct_code_t d,
              input logic [15:0] w, output cct_pkg::cct_sample_t g);
        int n;
        n = cct_sink_model_inst.gotQ.size();
        send(s, d, w);
        @(negedge mclk);
        inValid = 1'b0;
        for (int i = 0; i < 20 && cct_sink_model_inst.gotQ.size() == n; i++) @(negedge mclk);
        g = (cct_sink_model_inst.gotQ.size() > n) ? cct_sink_model_inst.gotQ[n] : 'x;
    endtask
    task row(input cct_pkg::cct_code_t s, input cct_pkg::cct_code_t d,
             input logic [15:0] w, input logic [18:0] e);
        xlat(s, d, w, got);
        check(got, e);
    endtask
    task testCodes;
        for (int s = 0; s < 10; s++) begin
            for (int d = 0; d < 10; d++) begin
                row(cct_pkg::cct_code_t'(s), cct_pkg::cct_code_t'(d), fiveTab[s],
                    {fiveTab[d], 3'b000});
            end
        end
    endtask
    task testValues;
        row(cct_pkg::CODE_STRAIGHT, cct_pkg::CODE_COMP_BIN, 16'h0000, {16'h00FF, 3'b000});
        row(cct_pkg::CODE_STRAIGHT, cct_pkg::CODE_BCD, 16'h0080, {16'h0128, 3'b000});
        row(cct_pkg::CODE_STRAIGHT, cct_pkg::CODE_BCD, 16'h00FF, {16'h0255, 3'b000});
        row(cct_pkg::CODE_OFFSET, cct_pkg::CODE_TWOS, 16'h0000, {16'h0080, 3'b000});
        row(cct_pkg::CODE_OFFSET, cct_pkg::CODE_SIGN_BCD, 16'h00FF, {16'h4127, 3'b000});
        row(cct_pkg::CODE_OFFSET, cct_pkg::CODE_SIGN_MAG, 16'h0080, {16'h0080, 3'b000});
        row(cct_pkg::CODE_TWOS, cct_pkg::CODE_SIGN_MAG, 16'h0080, {16'h007F, 3'b010});
        row(cct_pkg::CODE_SIGN_MAG, cct_pkg::CODE_TWOS, 16'h0000, {16'h0000, 3'b001});
        row(cct_pkg::CODE_SIGN_MAG, cct_pkg::CODE_TWOS, 16'h007F, {16'h0081, 3'b000});
        row(cct_pkg::CODE_TWOS, cct_pkg::CODE_OFFSET, 16'h00E0, {16'h0060, 3'b000});
        row(cct_pkg::CODE_BCD, cct_pkg::CODE_COMP_BCD, 16'h0999, {16'h0666, 3'b000});
        row(cct_pkg::CODE_BCD_OVR, cct_pkg::CODE_SIGN_BCD, 16'h1999, {16'h5999, 3'b000});
        row(cct_pkg::CODE_BCD_OVR, cct_pkg::CODE_BCD, 16'h3999, {16'h0999, 3'b010});
        row(cct_pkg::CODE_SIGN_BCD, cct_pkg::CODE_TWOS, 16'h0005, {16'h00FB, 3'b000});
        xlat(cct_pkg::CODE_BCD, cct_pkg::CODE_STRAIGHT, 16'h00A5, got);
        check({18'h0_0000, got.flags.invalid}, 19'h0_0001);
        xlat(cct_pkg::CODE_OFFSET, cct_pkg::CODE_TWOS, 16'h00E0, got);
        xlat(cct_pkg::CODE_OFFSET, cct_pkg::CODE_TWOS, 16'h0020, got2);
        check({10'h000, 9'(got.word[7:0]) + 9'(got2.word[7:0])}, 19'h0_0100);
    endtask
    task testStall;
        int n;
        n = cct_sink_model_inst.gotQ.size();
        @(negedge mclk);
        stall = 1'b1;
        for (int k = 1; k <= 3; k++) send(cct_pkg::CODE_STRAIGHT, cct_pkg::CODE_STRAIGHT, 16'(k));
        @(negedge mclk);
        check({18'h0_0000, inReady}, 19'h0_0000);
        repeat (3) @(negedge mclk);
        stall = 1'b0;
        xlat(cct_pkg::CODE_STRAIGHT, cct_pkg::CODE_STRAIGHT, 16'h0004, got);
        for (int i = 0; i < 20 && cct_sink_model_inst.gotQ.size() < n + 4; i++) @(negedge mclk);
        for (int k = 0; k < 4; k++) begin
            check(cct_sink_model_inst.gotQ[n+k], {16'(k + 1), 3'b000});
        end
    endtask
    task testClear;
        @(negedge mclk);
        stall = 1'b1;
        send(cct_pkg::CODE_STRAIGHT, cct_pkg::CODE_STRAIGHT, 16'h0009);
        @(negedge mclk);
        inValid = 1'b0;
        syncClr = 1'b1;
        @(negedge mclk);
        syncClr = 1'b0;
        check({18'h0_0000, outValid}, 19'h0_0000);
        stall = 1'b0;
        row(cct_pkg::CODE_STRAIGHT, cct_pkg::CODE_COMP_BIN, 16'h0003, {16'h00FC, 3'b000});
    endtask
    initial begin
        errors = 0;
        tests_run = 0;
        reset = 1'b1;
        syncClr = 1'b0;
        inValid = 1'b0;
        stall = 1'b0;
        srcCode = cct_pkg::CODE_STRAIGHT;
        dstCode = cct_pkg::CODE_STRAIGHT;
        inWord = 16'h0000;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        reset = 1'b0;
        testCodes();
        testValues();
        testStall();
        testClear();
        conclude();
    end
    initial begin
        #200000;
        errors++;
        conclude();
    end
endmodule
